// [src/half_cycle_counter.sv]
// Counts half line cycles and marks the end of a line-cycle integration.
`timescale 1ns/1ps
module half_cycle_counter #(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic enable,
    input wire logic half_cycle_tick,
    input wire logic [CNT_W-1:0] target,
    output logic done
);

    generate
        if (CNT_W < 1)
        begin : g_bad_width
            $error("half_cycle_counter needs CNT_W of at least 1");
        end
    endgenerate

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_COUNT = 2'b10
    } cnt_state_e;

    typedef struct packed {
        cnt_state_e state_r;
        logic [CNT_W-1:0] count_r;
        logic done_r;
    } cnt_s;

    cnt_s st_r;
    cnt_s st_nxt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // A target of zero never completes an integration.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.done_r = 1'b0;
        case (st_r.state_r)
            ST_IDLE:
            begin
                st_nxt.count_r = '0;
                if (enable)
                begin
                    st_nxt.state_r = ST_COUNT;
                end
            end
            ST_COUNT:
            begin
                if (!enable)
                begin
                    st_nxt.state_r = ST_IDLE;
                end
                else if (half_cycle_tick)
                begin
                    if (st_r.count_r + CNT_W'(1) >= target && target != '0)
                    begin
                        st_nxt.count_r = '0;
                        st_nxt.done_r = 1'b1;
                    end
                    else
                    begin
                        st_nxt.count_r = st_r.count_r + CNT_W'(1);
                    end
                end
            end
            default:
            begin
                st_nxt.state_r = ST_IDLE;
                st_nxt.count_r = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            st_r <= '{state_r: ST_IDLE, count_r: '0, done_r: 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign done = st_r.done_r;

endmodule : half_cycle_counter

// [src/level_edge_detect.sv]
// Registered edge detector over a vector of same-clock levels.
`timescale 1ns/1ps
module level_edge_detect #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);

    generate
        if (WIDTH < 1)
        begin : g_bad_width
            $error("level_edge_detect needs WIDTH of at least 1");
        end
    endgenerate

    typedef struct packed {
        logic armed_r;
        logic [WIDTH-1:0] prev_r;
    } edge_s;

    edge_s st_r;
    edge_s st_nxt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // The first sample after reset only loads the history, so a level
    // that is already high at release is not taken for an edge.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.armed_r = 1'b1;
        st_nxt.prev_r = level;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rise = st_r.armed_r ? (level & ~st_r.prev_r) : '0;
    assign fall = st_r.armed_r ? (~level & st_r.prev_r) : '0;

endmodule : level_edge_detect

// [src/meter_event_status_flags.sv]
// Event status flag register and power sign register of the metering core.
// Behaviour
// RQ1: Bit 0 sets when bit 30 of any phase active energy toggles.
// RQ2: Bits 1 and 3 always read zero.
// RQ3: Bit 2 sets when bit 30 of any phase reactive energy toggles.
// RQ4: Bit 4 sets when bit 30 of any phase apparent energy toggles.
// RQ5: Bit 5 sets when line-cycle integration over the half-cycle count ends.
// RQ6: Bits 6-8 flag phase active sign changes; signs in sign bits 0-2.
// RQ7: Bit 9 flags pulse 1 sum sign change; sign in sign bit 3.
// RQ8: Bits 10-12 flag phase reactive sign changes; signs in bits 4-6.
// RQ9: Bit 13 flags pulse 2 sum sign change; sign in sign bit 7.
// RQ10: Bit 14 sets on a falling edge of pulse output 1.
// RQ11: Pulse 1 flag still sets while its pin is disabled.
// RQ12: Mode bits 2-0 pick the power type behind pulse output 1.
// RQ13: Bit 15 sets on a falling edge of pulse output 2.
// RQ14: Pulse 2 flags while disabled by mode bit 10; type from bits 5-3.
// RQ15: Bit 16 flags pulse 3 falling edge, even disabled; type bits 8-6.
// RQ16: Bit 17 sets when the periodic signal processing pass finishes.
// RQ17: Bit 18 flags pulse 3 sum sign change; sign in sign bit 8.
// RQ18: Flags clear at reset and stay set until software clears them.
// RQ19: Flags set only on a new occurrence of the event.
`timescale 1ns/1ps
module meter_event_status_flags (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [15:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [2:0] phase_active_energy_b30,
    input wire logic [2:0] phase_reactive_energy_b30,
    input wire logic [2:0] phase_apparent_energy_b30,
    input wire logic line_cycle_mode,
    input wire logic half_cycle_tick,
    input wire logic [15:0] half_cycle_count_reg,
    input wire logic [2:0] phase_active_neg,
    input wire logic [2:0] phase_reactive_neg,
    input wire logic total_active_neg,
    input wire logic total_reactive_neg,
    input wire logic [15:0] pulse_output_mode_reg,
    input wire logic [2:0] pulse_gen_level,
    input wire logic dsp_cycle_done,
    output logic [2:0] pulse_out_pin,
    output logic [31:0] event_status_zero,
    output logic [8:0] power_sign_reg
);

    localparam int EDGE_W = 22;
    localparam int E_ACT = 0;
    localparam int E_REACT = 3;
    localparam int E_APP = 6;
    localparam int E_SIGN = 9;
    localparam int E_PULSE = 18;
    localparam int E_DSP = 21;

    typedef struct packed {
        logic [31:0] status_r;
        logic [8:0] sign_r;
        logic [31:0] rdata_r;
        logic rvalid_r;
        logic [2:0] pin_r;
    } flags_s;

    flags_s st_r;
    flags_s st_nxt;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The edge vector layout and the sign register width must agree with the
    // packing below, or events would land on the wrong status bits.
    generate
        if (E_DSP != EDGE_W - 1 || E_PULSE + 3 != E_DSP)
        begin : g_bad_edge_layout
            $error("meter_event_status_flags edge vector layout is inconsistent");
        end
        if (meter_status_pkg::SIGN_W != E_PULSE - E_SIGN)
        begin : g_bad_sign_width
            $error("meter_event_status_flags sign width does not match the edge vector");
        end
    endgenerate

    logic [8:0] sign_now;
    logic [EDGE_W-1:0] edge_level;
    logic [EDGE_W-1:0] edge_rise;
    logic [EDGE_W-1:0] edge_fall;
    logic line_done;
    logic [31:0] set_vec;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Sign of the summed power that a pulse output accumulates; apparent
    // power is never negative, unknown codes fall back to active power.
    function automatic logic sum_sign(input logic [2:0] sel, input logic act_neg, input logic react_neg);
        logic s;
        s = act_neg;
        case (sel)
            meter_status_pkg::SEL_ACTIVE: s = act_neg;
            meter_status_pkg::SEL_REACTIVE: s = react_neg;
            meter_status_pkg::SEL_APPARENT: s = 1'b0;
            default: s = act_neg;
        endcase
        return s;
    endfunction : sum_sign

    function automatic logic [2:0] mode_sel(input logic [15:0] mode, input int lsb);
        return mode[lsb +: 3];
    endfunction : mode_sel

    // ------------------------------------------------------------
    // Sign gathering
    // ------------------------------------------------------------
    always_comb
    begin
        sign_now = meter_status_pkg::SIGN_RESET;
        // RQ6 active phase signs
        sign_now[meter_status_pkg::SIGN_ACT_A +: 3] = phase_active_neg;
        // RQ8 reactive phase signs
        sign_now[meter_status_pkg::SIGN_REACT_A +: 3] = phase_reactive_neg;
        // RQ12 pulse 1 type
        sign_now[meter_status_pkg::SIGN_SUM1] = sum_sign(
            mode_sel(pulse_output_mode_reg, meter_status_pkg::MODE_SEL1_LSB),
            total_active_neg, total_reactive_neg);
        // RQ14 pulse 2 type
        sign_now[meter_status_pkg::SIGN_SUM2] = sum_sign(
            mode_sel(pulse_output_mode_reg, meter_status_pkg::MODE_SEL2_LSB),
            total_active_neg, total_reactive_neg);
        // RQ15 pulse 3 type
        sign_now[meter_status_pkg::SIGN_SUM3] = sum_sign(
            mode_sel(pulse_output_mode_reg, meter_status_pkg::MODE_SEL3_LSB),
            total_active_neg, total_reactive_neg);
    end

    assign edge_level = {dsp_cycle_done, pulse_gen_level, sign_now, phase_apparent_energy_b30,
                         phase_reactive_energy_b30, phase_active_energy_b30};

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    // RQ19 edge triggered events
    level_edge_detect #(
        .WIDTH(EDGE_W)
    ) u_edges (
        .mclk(mclk),
        .reset(reset),
        .level(edge_level),
        .rise(edge_rise),
        .fall(edge_fall)
    );

    // RQ5 line cycle end
    half_cycle_counter #(
        .CNT_W(meter_status_pkg::LINE_CNT_W)
    ) u_line (
        .mclk(mclk),
        .reset(reset),
        .enable(line_cycle_mode),
        .half_cycle_tick(half_cycle_tick),
        .target(half_cycle_count_reg),
        .done(line_done)
    );

    always_comb
    begin
        logic [EDGE_W-1:0] chg;
        chg = edge_rise | edge_fall;
        set_vec = '0;
        // RQ1 active half flag
        set_vec[meter_status_pkg::BIT_ACTIVE_HALF] = |chg[E_ACT +: 3];
        // RQ3 reactive half flag
        set_vec[meter_status_pkg::BIT_REACTIVE_HALF] = |chg[E_REACT +: 3];
        // RQ4 apparent half flag
        set_vec[meter_status_pkg::BIT_APPARENT_HALF] = |chg[E_APP +: 3];
        // RQ5 line cycle flag
        set_vec[meter_status_pkg::BIT_LINE_DONE] = line_done;
        // RQ6 active sign flips
        set_vec[meter_status_pkg::BIT_ACT_FLIP_A +: 3] = chg[E_SIGN + meter_status_pkg::SIGN_ACT_A +: 3];
        // RQ7 pulse 1 sum flip
        set_vec[meter_status_pkg::BIT_SUM1_FLIP] = chg[E_SIGN + meter_status_pkg::SIGN_SUM1];
        // RQ8 reactive sign flips
        set_vec[meter_status_pkg::BIT_REACT_FLIP_A +: 3] = chg[E_SIGN + meter_status_pkg::SIGN_REACT_A +: 3];
        // RQ9 pulse 2 sum flip
        set_vec[meter_status_pkg::BIT_SUM2_FLIP] = chg[E_SIGN + meter_status_pkg::SIGN_SUM2];
        // RQ17 pulse 3 sum flip
        set_vec[meter_status_pkg::BIT_SUM3_FLIP] = chg[E_SIGN + meter_status_pkg::SIGN_SUM3];
        // RQ10 RQ11 pulse 1 falling
        set_vec[meter_status_pkg::BIT_PULSE1] = edge_fall[E_PULSE];
        // RQ13 RQ14 pulse 2 falling
        set_vec[meter_status_pkg::BIT_PULSE2] = edge_fall[E_PULSE + 1];
        // RQ15 pulse 3 falling
        set_vec[meter_status_pkg::BIT_PULSE3] = edge_fall[E_PULSE + 2];
        // RQ16 processing done
        set_vec[meter_status_pkg::BIT_DSP_DONE] = edge_rise[E_DSP];
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    always_comb
    begin
        logic wr_status;
        logic [31:0] clr;
        st_nxt = st_r;
        wr_status = reg_wr && (reg_addr == meter_status_pkg::ADDR_EVENT_STATUS_ZERO);
        clr = wr_status ? reg_wdata : '0;
        // RQ18 sticky, write one to clear, set beats clear
        st_nxt.status_r = ((st_r.status_r & ~clr) | set_vec) & meter_status_pkg::STATUS_USED_MASK;
        // RQ2 reserved bits zero
        st_nxt.status_r[meter_status_pkg::BIT_RSVD_A] = 1'b0;
        st_nxt.status_r[meter_status_pkg::BIT_RSVD_B] = 1'b0;
        st_nxt.sign_r = sign_now;
        // RQ11 disable gates only the pin
        st_nxt.pin_r[0] = pulse_gen_level[0] | pulse_output_mode_reg[meter_status_pkg::MODE_DIS1];
        st_nxt.pin_r[1] = pulse_gen_level[1] | pulse_output_mode_reg[meter_status_pkg::MODE_DIS2];
        st_nxt.pin_r[2] = pulse_gen_level[2] | pulse_output_mode_reg[meter_status_pkg::MODE_DIS3];
        st_nxt.rvalid_r = reg_rd;
        if (reg_rd)
        begin
            case (reg_addr)
                meter_status_pkg::ADDR_EVENT_STATUS_ZERO: st_nxt.rdata_r = st_r.status_r;
                meter_status_pkg::ADDR_POWER_SIGN_REG: st_nxt.rdata_r = {23'h000000, st_r.sign_r};
                default: st_nxt.rdata_r = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            st_r <= '{status_r: meter_status_pkg::STATUS_RESET, sign_r: meter_status_pkg::SIGN_RESET,
                      rdata_r: 32'h0000_0000, rvalid_r: 1'b0, pin_r: 3'h7};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata_r;
    assign reg_rvalid = st_r.rvalid_r;
    assign pulse_out_pin = st_r.pin_r;
    assign event_status_zero = st_r.status_r;
    assign power_sign_reg = st_r.sign_r;

endmodule : meter_event_status_flags

// [src/meter_status_pkg.sv]
// Shared constants of the event status flag bank.
package meter_status_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_EVENT_STATUS_ZERO = 16'hE502;
    localparam logic [15:0] ADDR_POWER_SIGN_REG = 16'hE617;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int SIGN_W = 9;
    localparam int LINE_CNT_W = 16;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [8:0] SIGN_RESET = 9'h000;

    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int BIT_ACTIVE_HALF = 0;
    localparam int BIT_RSVD_A = 1;
    localparam int BIT_REACTIVE_HALF = 2;
    localparam int BIT_RSVD_B = 3;
    localparam int BIT_APPARENT_HALF = 4;
    localparam int BIT_LINE_DONE = 5;
    localparam int BIT_ACT_FLIP_A = 6;
    localparam int BIT_SUM1_FLIP = 9;
    localparam int BIT_REACT_FLIP_A = 10;
    localparam int BIT_SUM2_FLIP = 13;
    localparam int BIT_PULSE1 = 14;
    localparam int BIT_PULSE2 = 15;
    localparam int BIT_PULSE3 = 16;
    localparam int BIT_DSP_DONE = 17;
    localparam int BIT_SUM3_FLIP = 18;
    localparam logic [31:0] STATUS_USED_MASK = 32'h0007_FFF5;

    // ------------------------------------------------------------
    // Power sign register bit positions
    // ------------------------------------------------------------
    localparam int SIGN_ACT_A = 0;
    localparam int SIGN_SUM1 = 3;
    localparam int SIGN_REACT_A = 4;
    localparam int SIGN_SUM2 = 7;
    localparam int SIGN_SUM3 = 8;

    // ------------------------------------------------------------
    // Pulse output mode register fields
    // ------------------------------------------------------------
    localparam int MODE_SEL1_LSB = 0;
    localparam int MODE_SEL2_LSB = 3;
    localparam int MODE_SEL3_LSB = 6;
    localparam int MODE_DIS1 = 9;
    localparam int MODE_DIS2 = 10;
    localparam int MODE_DIS3 = 11;
    localparam logic [2:0] SEL_ACTIVE = 3'h0;
    localparam logic [2:0] SEL_REACTIVE = 3'h1;
    localparam logic [2:0] SEL_APPARENT = 3'h2;

endpackage : meter_status_pkg

// [tb/meter_event_status_flags_checker.sv]
// Concurrent checks on the ports of the event status flag bank.
`timescale 1ns/1ps
module meter_event_status_flags_checker (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [15:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [2:0] phase_active_energy_b30,
    input wire logic [2:0] phase_active_neg,
    input wire logic [2:0] phase_reactive_neg,
    input wire logic [15:0] pulse_output_mode_reg,
    input wire logic [2:0] pulse_gen_level,
    input wire logic dsp_cycle_done,
    input wire logic [2:0] pulse_out_pin,
    input wire logic [31:0] event_status_zero,
    input wire logic [8:0] power_sign_reg
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    // Armed from the first edge after reset, so no check sees pre-reset history.
    logic armed_r;
    logic [31:0] keep;
    assign keep = event_status_zero & ~((reg_wr && reg_addr == meter_status_pkg::ADDR_EVENT_STATUS_ZERO) ?
        reg_wdata : 32'h0000_0000);
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            armed_r <= 1'b0;
        else
            armed_r <= 1'b1;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    rsvd_zero_a: assert property ((event_status_zero & ~meter_status_pkg::STATUS_USED_MASK) == 32'h0000_0000)
        else $error("reserved status bits not zero");
    flag_hold_a: assert property (armed_r |=> (event_status_zero & $past(keep)) == $past(keep))
        else $error("status flag lost without a clear");
    act_half_a: assert property (armed_r && $changed(phase_active_energy_b30) && !reg_wr |-> ##[1:2] event_status_zero[0])
        else $error("active energy half flag missing");
    pulse1_flag_a: assert property (armed_r && $fell(pulse_gen_level[0]) && !reg_wr |-> ##[1:2] event_status_zero[14])
        else $error("pulse 1 flag missing");
    pulse3_flag_a: assert property (armed_r && $fell(pulse_gen_level[2]) && !reg_wr |-> ##[1:2] event_status_zero[16])
        else $error("pulse 3 flag missing");
    dsp_done_a: assert property (armed_r && $rose(dsp_cycle_done) && !reg_wr |-> ##[1:2] event_status_zero[17])
        else $error("processing done flag missing");
    sign_track_a: assert property (armed_r |-> power_sign_reg[2:0] == $past(phase_active_neg) &&
        power_sign_reg[6:4] == $past(phase_reactive_neg))
        else $error("phase sign register wrong");
    pin_drive_a: assert property (armed_r |-> pulse_out_pin == $past(pulse_gen_level | pulse_output_mode_reg[11:9]))
        else $error("pulse pin drive wrong");
    read_data_a: assert property (reg_rd && reg_addr == meter_status_pkg::ADDR_EVENT_STATUS_ZERO |=>
        reg_rvalid && reg_rdata == $past(event_status_zero))
        else $error("status read wrong");
endmodule : meter_event_status_flags_checker

bind meter_event_status_flags meter_event_status_flags_checker chk_u (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .phase_active_energy_b30(phase_active_energy_b30), .phase_active_neg(phase_active_neg),
    .phase_reactive_neg(phase_reactive_neg), .pulse_output_mode_reg(pulse_output_mode_reg),
    .pulse_gen_level(pulse_gen_level), .dsp_cycle_done(dsp_cycle_done), .pulse_out_pin(pulse_out_pin),
    .event_status_zero(event_status_zero), .power_sign_reg(power_sign_reg));

// [tb/meter_event_status_flags_tb.sv]
// Self-checking bench of the event status flag bank.
`timescale 1ns/1ps
module meter_event_status_flags_tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata, st, exp_st = 32'h0000_0000, rng = 32'h0000_FA7B;
    logic reg_rvalid, line_mode = 1'b0, tick = 1'b0, ta = 1'b0, tr = 1'b0, dsp = 1'b0;
    logic [2:0] ae = 3'h0, re = 3'h0, pe = 3'h0, an = 3'h0, rn = 3'h0, lvl = 3'h7, pin;
    logic [15:0] mode = 16'h0000;
    logic [8:0] sgn;
    logic [31:0] q[$];
    int n_fail = 0;
    int n_tests = 0;

    always #20 mclk = ~mclk;

    meter_event_status_flags dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .phase_active_energy_b30(ae), .phase_reactive_energy_b30(re), .phase_apparent_energy_b30(pe),
        .line_cycle_mode(line_mode), .half_cycle_tick(tick), .half_cycle_count_reg(16'h0003),
        .phase_active_neg(an), .phase_reactive_neg(rn), .total_active_neg(ta), .total_reactive_neg(tr),
        .pulse_output_mode_reg(mode), .pulse_gen_level(lvl), .dsp_cycle_done(dsp), .pulse_out_pin(pin),
        .event_status_zero(st), .power_sign_reg(sgn));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] nxt();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : nxt

    function automatic logic sum_sign(input logic [2:0] s);
        return (s == 3'h1) ? tr : ((s == 3'h2) ? 1'b0 : ta);
    endfunction : sum_sign

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e)
        begin
            $display("[ERR] %s expected %h seen %h", what, e, s);
            n_fail++;
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask : idle

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        q.push_back(e);
        @(negedge mclk);
        reg_rd = 1'b0;
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        if (a == meter_status_pkg::ADDR_EVENT_STATUS_ZERO)
            exp_st = exp_st & ~d;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd_all();
        rd(meter_status_pkg::ADDR_EVENT_STATUS_ZERO, exp_st);
        rd(meter_status_pkg::ADDR_POWER_SIGN_REG, {23'h0, sum_sign(mode[8:6]), sum_sign(mode[5:3]), rn,
            sum_sign(mode[2:0]), an});
    endtask : rd_all

    // Causes one event of kind k on a random phase or pulse output (none for kind 6, processing done), checks the flag, clears it and checks it stays clear.
    task automatic ev(input int k);
        int b;
        logic [1:0] p;
        p = 2'(nxt() % 32'h3);
        b = (k < 3) ? 2 * k : (k == 3 ? 6 + p : (k == 4 ? 10 + p : (k == 5 ? 14 + p : 17)));
        @(negedge mclk);
        case (k)
            0: ae[p] = ~ae[p];
            1: re[p] = ~re[p];
            2: pe[p] = ~pe[p];
            3: an[p] = ~an[p];
            4: rn[p] = ~rn[p];
            5: lvl[p] = 1'b0;
            default: dsp = 1'b1;
        endcase
        exp_st[b] = 1'b1;
        @(negedge mclk);
        check("pulse pin", {29'h0, lvl | mode[11:9]}, {29'h0, pin});
        lvl = 3'h7;
        dsp = 1'b0;
        idle(2);
        rd_all();
        wr(meter_status_pkg::ADDR_EVENT_STATUS_ZERO, nxt() | (32'h1 << b));
        idle(3);
        rd_all();
    endtask : ev

    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Read result monitor
    // ------------------------------------------------------------
    always @(negedge mclk)
    begin
        if (reg_rvalid === 1'b1)
        begin
            if (q.size() == 0)
                check("unexpected read", 32'h0, 32'h1);
            else
                check("read data", q.pop_front(), reg_rdata);
        end
    end

    initial
    begin
        #(20000 * 40);
        n_fail++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        idle(6);
        reset = 1'b0;
        idle(2);
        rd_all();
        rd(16'h1234, 32'h0);
        wr(16'h1234, 32'hFFFF_FFFF);
        wr(meter_status_pkg::ADDR_POWER_SIGN_REG, 32'hFFFF_FFFF);
        rd_all();
        for (int pass = 0; pass < 2; pass++)
        begin
            @(negedge mclk);
            mode = {4'h0, 3'(pass * 7), 9'h000};
            for (int k = 0; k < 7; k++)
                ev(k);
        end
        for (int s = 0; s < 4; s++)
        begin
            @(negedge mclk);
            mode = {4'h0, 3'(nxt()), 3'(s), 3'(s), 3'(s)};
            idle(3);
            wr(meter_status_pkg::ADDR_EVENT_STATUS_ZERO, 32'hFFFF_FFFF);
            @(negedge mclk);
            ta = ~ta;
            tr = ~tr;
            exp_st = exp_st | ((s == 2) ? 32'h0 : 32'h0004_2200);
            idle(3);
            rd_all();
        end
        @(negedge mclk);
        line_mode = 1'b1;
        idle(2);
        for (int i = 0; i < 3; i++)
        begin
            @(negedge mclk);
            tick = 1'b1;
            @(negedge mclk);
            tick = 1'b0;
            idle(2);
            exp_st[5] = (i == 2);
            rd_all();
        end
        idle(4);
        if (q.size() != 0)
            check("pending reads", 32'h0, 32'(q.size()));
        finish_test();
    end
endmodule : meter_event_status_flags_tb
